// ===== rtl/iiport_pkg.sv
package iiport_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [1:0] OFS_INPUTS_LOW_BYTE_AND_IRQ0_CLEAR = 2'h0;
   localparam logic [1:0] OFS_INPUTS_SECOND_BYTE = 2'h1;
   localparam logic [1:0] OFS_INPUTS_THIRD_BYTE_AND_IRQ16_CLEAR = 2'h2;
   localparam logic [1:0] OFS_INPUTS_HIGH_BYTE = 2'h3;

   // ---------------------------------------------------------------
   // Address and channel layout
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int BASE_MSB = 9;
   localparam int BASE_LSB = 2;
   localparam logic [7:0] BASE_SWITCH_FACTORY = 8'hC0;
   localparam int CH_W = 32;
   localparam int BYTE_W = 8;
   localparam int IRQ_SRC_N = 2;
   localparam int IRQ_SRC0_BIT = 0;
   localparam int IRQ_SRC1_BIT = 16;
   localparam int IRQ_LEVEL_N = 8;
   localparam logic [CH_W-1:0] INPUTS_RESET = 32'h0000_0000;
   localparam logic [BYTE_W-1:0] READ_IDLE = 8'h00;

   // Host interrupt lines in order: 2, 3, 5, 7, 10, 11, 12, 15.
   localparam logic [IRQ_LEVEL_N-1:0] IRQ_LEVELS_NONE = 8'h00;

   typedef struct packed {
      logic [CH_W-1:0] inputs;
      logic [IRQ_SRC_N-1:0] prev;
      logic [IRQ_SRC_N-1:0] flag;
      logic [BYTE_W-1:0] rdata;
      logic [IRQ_LEVEL_N-1:0] irq;
   } iiport_state_t;

endpackage

// ===== rtl/iiport_top.sv
`timescale 1ns/10ps
module iiport_top
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [iiport_pkg::ADDR_W-1:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [iiport_pkg::BYTE_W-1:0] io_wdata,
   input wire logic [7:0] base_address_switch,
   input wire logic [iiport_pkg::CH_W-1:0] isolated_input_channel,
   input wire logic [iiport_pkg::IRQ_LEVEL_N-1:0] irq_level_jumper_zero,
   input wire logic [iiport_pkg::IRQ_LEVEL_N-1:0]
      irq_level_jumper_sixteen,
   input wire logic first_edge_select_jumper,
   input wire logic second_edge_select_jumper,
   output logic [iiport_pkg::BYTE_W-1:0] io_rdata,
   output logic [iiport_pkg::IRQ_LEVEL_N-1:0] host_irq,
   output logic [iiport_pkg::IRQ_SRC_N-1:0] irq_flag
);
   import iiport_pkg::*;

   iiport_state_t s_q;
   iiport_state_t s_d;
   logic hit;
   logic [1:0] ofs;
   logic [IRQ_SRC_N-1:0] cur;
   logic [IRQ_SRC_N-1:0] rise_sel;
   logic [IRQ_SRC_N-1:0] edge_hit;
   logic [IRQ_SRC_N-1:0] clr;
   logic [IRQ_LEVEL_N-1:0] jumper [IRQ_SRC_N];

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   assign hit = (io_addr[BASE_MSB:BASE_LSB] == base_address_switch);
   assign ofs = io_addr[1:0];

   assign cur = {s_q.inputs[IRQ_SRC1_BIT], s_q.inputs[IRQ_SRC0_BIT]};
   assign rise_sel = {second_edge_select_jumper, first_edge_select_jumper};
   assign jumper[0] = irq_level_jumper_zero;
   assign jumper[1] = irq_level_jumper_sixteen;
   assign clr[0] = hit && io_wr
      && ofs == OFS_INPUTS_LOW_BYTE_AND_IRQ0_CLEAR;
   assign clr[1] = hit && io_wr
      && ofs == OFS_INPUTS_THIRD_BYTE_AND_IRQ16_CLEAR;

   // ---------------------------------------------------------------
   // Edge detection per interrupt source
   // ---------------------------------------------------------------
   // A jumper high selects the rising edge, low the falling edge.
   for (genvar i = 0; i < IRQ_SRC_N; i++)
   begin : g_src
      assign edge_hit[i] = rise_sel[i] ? (cur[i] && !s_q.prev[i])
                                      : (!cur[i] && s_q.prev[i]);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.inputs = isolated_input_channel;
      s_d.prev = cur;
      // A new edge in the clearing cycle wins, so no event is lost.
      s_d.flag = (s_q.flag & ~clr) | edge_hit;
      s_d.rdata = READ_IDLE;
      if (hit && io_rd)
      begin
         unique case (ofs)
            OFS_INPUTS_LOW_BYTE_AND_IRQ0_CLEAR: s_d.rdata = s_q.inputs[7:0];
            OFS_INPUTS_SECOND_BYTE: s_d.rdata = s_q.inputs[15:8];
            OFS_INPUTS_THIRD_BYTE_AND_IRQ16_CLEAR:
               s_d.rdata = s_q.inputs[23:16];
            OFS_INPUTS_HIGH_BYTE: s_d.rdata = s_q.inputs[31:24];
         endcase
      end
      s_d.irq = IRQ_LEVELS_NONE;
      for (int i = 0; i < IRQ_SRC_N; i++)
      begin
         if (s_d.flag[i])
         begin
            s_d.irq = s_d.irq | jumper[i];
         end
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_q <= '{inputs: INPUTS_RESET, prev: '0, flag: '0,
                  rdata: READ_IDLE, irq: IRQ_LEVELS_NONE};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign io_rdata = s_q.rdata;
   assign host_irq = s_q.irq;
   assign irq_flag = s_q.flag;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_edge_sets_flag: assert property (
      @(posedge clk) disable iff (reset)
      edge_hit[0] |=> irq_flag[0])
      else $error("Channel 0 edge did not set its flag.");

   chk_flag_holds: assert property (
      @(posedge clk) disable iff (reset)
      irq_flag[1] && !clr[1] |=> irq_flag[1])
      else $error("Channel 16 flag dropped without a clear.");

   chk_clear_flag: assert property (
      @(posedge clk) disable iff (reset)
      clr[0] && !edge_hit[0] |=> !irq_flag[0])
      else $error("Write to offset 0 did not clear flag.");

   chk_no_jumper_quiet: assert property (
      @(posedge clk) disable iff (reset)
      (irq_level_jumper_zero == '0 && irq_level_jumper_sixteen == '0)
      |=> host_irq == '0)
      else $error("Interrupt raised with no level jumper.");

   chk_irq_routing: assert property (
      @(posedge clk) disable iff (reset)
      irq_flag[0] && !irq_flag[1]
      |-> host_irq == $past(irq_level_jumper_zero))
      else $error("Channel 0 request on wrong level.");

   chk_read_byte1: assert property (
      @(posedge clk) disable iff (reset)
      hit && io_rd && ofs == OFS_INPUTS_SECOND_BYTE
      |=> io_rdata == $past(s_q.inputs[15:8]))
      else $error("Offset 1 read returned wrong byte.");

   chk_miss_idle: assert property (
      @(posedge clk) disable iff (reset)
      !hit |=> io_rdata == READ_IDLE)
      else $error("Read data driven for foreign address.");

   chk_odd_write: assert property (
      @(posedge clk) disable iff (reset)
      io_wr && ofs[0] && !edge_hit[0] && irq_flag[0] |=> irq_flag[0])
      else $error("Write to offset 1 or 3 cleared a flag.");

   // ---------------------------------------------------------------
   // Further checks for both sources, the level routing and the read path
   // ---------------------------------------------------------------
   chk_edge_flag16: assert property (
      @(posedge clk) disable iff (reset)
      edge_hit[1] |=> irq_flag[1])
      else $error("Channel 16 edge did not set its flag.");

   chk_rise_seen: assert property (
      @(posedge clk) disable iff (reset)
      $rose(cur[0]) && first_edge_select_jumper |=> irq_flag[0])
      else $error("Channel 0 rising edge missed.");

   chk_fall_seen16: assert property (
      @(posedge clk) disable iff (reset)
      $fell(cur[1]) && !second_edge_select_jumper |=> irq_flag[1])
      else $error("Channel 16 falling edge missed.");

   chk_clear_flag16: assert property (
      @(posedge clk) disable iff (reset)
      clr[1] && !edge_hit[1] |=> !irq_flag[1])
      else $error("Write to offset 2 did not clear flag.");

   chk_flag0_holds: assert property (
      @(posedge clk) disable iff (reset)
      irq_flag[0] && !clr[0] |=> irq_flag[0])
      else $error("Channel 0 flag dropped without a clear.");

   chk_irq16_routing: assert property (
      @(posedge clk) disable iff (reset)
      irq_flag[1] && !irq_flag[0]
      |-> host_irq == $past(irq_level_jumper_sixteen))
      else $error("Channel 16 request on wrong level.");

   chk_irq_both: assert property (
      @(posedge clk) disable iff (reset)
      irq_flag[0] && irq_flag[1]
      |-> host_irq == ($past(irq_level_jumper_zero)
                       | $past(irq_level_jumper_sixteen)))
      else $error("Combined request on wrong levels.");

   chk_no_flag_quiet: assert property (
      @(posedge clk) disable iff (reset)
      irq_flag == '0 |-> host_irq == '0)
      else $error("Interrupt raised with no flag set.");

   chk_flag0_needs_edge: assert property (
      @(posedge clk) disable iff (reset)
      !irq_flag[0] && !edge_hit[0] |=> !irq_flag[0])
      else $error("Channel 0 flag set without an edge.");

   chk_flag16_needs_edge: assert property (
      @(posedge clk) disable iff (reset)
      !irq_flag[1] && !edge_hit[1] |=> !irq_flag[1])
      else $error("Channel 16 flag set without an edge.");

   chk_read_byte0: assert property (
      @(posedge clk) disable iff (reset)
      hit && io_rd && ofs == OFS_INPUTS_LOW_BYTE_AND_IRQ0_CLEAR
      |=> io_rdata == $past(s_q.inputs[7:0]))
      else $error("Offset 0 read returned wrong byte.");

   chk_read_byte2: assert property (
      @(posedge clk) disable iff (reset)
      hit && io_rd && ofs == OFS_INPUTS_THIRD_BYTE_AND_IRQ16_CLEAR
      |=> io_rdata == $past(s_q.inputs[23:16]))
      else $error("Offset 2 read returned wrong byte.");

   chk_read_byte3: assert property (
      @(posedge clk) disable iff (reset)
      hit && io_rd && ofs == OFS_INPUTS_HIGH_BYTE
      |=> io_rdata == $past(s_q.inputs[31:24]))
      else $error("Offset 3 read returned wrong byte.");

   chk_no_read_idle: assert property (
      @(posedge clk) disable iff (reset)
      !io_rd |=> io_rdata == READ_IDLE)
      else $error("Read data driven without a read.");

   chk_odd_write16: assert property (
      @(posedge clk) disable iff (reset)
      io_wr && ofs[0] && !edge_hit[1] && irq_flag[1] |=> irq_flag[1])
      else $error("Write to offset 1 or 3 cleared channel 16.");

endmodule

// ===== tb/iiport_host.sv
`timescale 1ns/10ps
module iiport_host
(
   input wire logic clk,
   output logic [9:0] io_addr,
   output logic io_rd,
   output logic io_wr,
   output logic [7:0] io_wdata
);
   initial {io_addr, io_rd, io_wr, io_wdata} = '0;
   // One bus cycle per call; the address is scrambled once released.
   task automatic cyc(input logic [9:0] a, input logic w);
      @(posedge clk) #2;
      io_addr = a;
      io_rd = !w;
      io_wr = w;
      io_wdata = ~a[7:0];
      @(posedge clk) #2;
      {io_rd, io_wr} = 2'b00;
      io_addr = ~a;
   endtask
endmodule

// ===== tb/iiport_top_bench.sv
`timescale 1ns/10ps
module iiport_top_bench;
   import iiport_pkg::*;
   logic clk, reset, e0, e1, io_rd, io_wr;
   logic [9:0] io_addr;
   logic [7:0] io_wdata, sw, jz, js, io_rdata, host_irq;
   logic [1:0] irq_flag;
   logic [31:0] din;
   int n_errors, tests_run, seed;
   iiport_host iiport_host_i(.clk(clk), .io_addr(io_addr), .io_rd(io_rd),
      .io_wr(io_wr), .io_wdata(io_wdata));
   iiport_top iiport_top_i(.clk(clk), .reset(reset), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
      .base_address_switch(sw), .isolated_input_channel(din),
      .irq_level_jumper_zero(jz), .irq_level_jumper_sixteen(js),
      .first_edge_select_jumper(e0), .second_edge_select_jumper(e1),
      .io_rdata(io_rdata), .host_irq(host_irq), .irq_flag(irq_flag));
   function automatic logic [7:0] byte_of(input logic [31:0] v, input int k);
      return v[k*8+:8];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flags(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t flags got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_irq(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t irq got %h expected %h", $time, got, exp);
      end
   endtask
   // Levels requested are the jumpers of the sources whose flag is set.
   function automatic logic [7:0] exp_irq(input logic [7:0] a,
      input logic [7:0] b, input logic [1:0] f);
      return (f[0] ? a : 8'h00) | (f[1] ? b : 8'h00);
   endfunction
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic setin(input logic a, input logic b);
      @(posedge clk) #2;
      din[0] = a;
      din[16] = b;
      repeat (4) @(posedge clk);
      #2;
   endtask
   task automatic wr(input logic [1:0] k);
      iiport_host_i.cyc({sw, k}, 1'b1);
      repeat (2) @(posedge clk);
      #2;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      #100000;
      n_errors++;
      end_of_test();
   end
   initial
   begin
      seed = 32'h88fa;
      {reset, e0, e1, jz, js, din, sw} = {3'b111, 48'h0, BASE_SWITCH_FACTORY};
      repeat (3) @(posedge clk);
      #2 reset = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         din = (i == 1) ? 32'hFFFF_FFFF : $random(seed);
         if (i > 2)
            sw = 8'($random(seed));
         for (int k = 0; k < 4; k++)
         begin
            iiport_host_i.cyc({sw, 2'(k)}, 1'b0);
            chk(io_rdata, byte_of(din, k));
         end
         iiport_host_i.cyc({~sw, 2'h1}, 1'b0);
         chk(io_rdata, READ_IDLE);
      end
      $display("read test done");
      for (int i = 0; i < 8; i++)
      begin
         e0 = i[0];
         e1 = ~i[0];
         jz = (i == 0) ? 8'h00 : 8'h01 << i;
         js = (i == 0 || i == 7) ? 8'h00 : 8'h80 >> i;
         setin(e0, e1);
         wr(2'h0);
         wr(2'h2);
         setin(~e0, ~e1);
         chk_flags(irq_flag, 2'h0);
         setin(e0, e1);
         chk_flags(irq_flag, 2'h3);
         chk_irq(host_irq, exp_irq(jz, js, 2'h3));
         wr(2'h1);
         wr(2'h3);
         chk_flags(irq_flag, 2'h3);
         iiport_host_i.cyc({~sw, 2'h0}, 1'b1);
         chk_flags(irq_flag, 2'h3);
         wr(2'h0);
         chk_irq(host_irq, exp_irq(jz, js, 2'h2));
         setin(~e0, ~e1);
         setin(e0, e1);
         chk_flags(irq_flag, 2'h3);
         wr(2'h0);
         wr(2'h2);
         chk_flags(irq_flag, 2'h0);
         chk_irq(host_irq, 8'h00);
         @(posedge clk) #2;
         din = din ^ 32'hFFFE_FFFE;
         repeat (4) @(posedge clk);
         #2;
         chk_flags(irq_flag, 2'h0);
      end
      $display("interrupt test done");
      end_of_test();
   end
endmodule
